/* File: rtl/trip_logic_pkg.sv */
// package: constants, configuration layout and helpers for the carrier trip logic
package trip_logic_pkg;

   // clock and millisecond tick
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned TICK_US = 1000;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;

   // millisecond figures of the channel logic
   localparam logic [10:0] GBT_MS = 11'h078;        // 120 ms guard before trip
   localparam logic [10:0] TAG_MS = 11'h078;        // 120 ms trip after guard
   localparam logic [10:0] OVR_TRIP_MS = 11'h3e8;   // 1000 ms trip for override
   localparam logic [10:0] OVR_RESTORE_MS = 11'h0c8; // 200 ms guard to restore
   localparam logic [10:0] MS_MAX = 11'h7ff;
   localparam logic [10:0] PRETRIP_STEP_MS = 11'h002;

   // register byte offsets
   localparam logic [7:0] CFG_UB_OFS = 8'h00;
   localparam logic [7:0] CFG_DTT_OFS = 8'h04;
   localparam logic [7:0] STATUS_OFS = 8'h08;

   // guard before trip modes
   localparam logic [1:0] GBT_OFF = 2'h0;
   localparam logic [1:0] GBT_ON = 2'h1;
   localparam logic [1:0] GBT_OVERRIDE = 2'h2;

   // configuration word, bit 0 upward: pretrip, trip stretch, guard stretch,
   // unblock window, noise block, guard-before-trip mode, low level delay
   typedef struct packed {
      logic [15:0] unused;
      logic [2:0] low_delay;
      logic [1:0] gbt_mode;
      logic noise_blocks_unblock;
      logic [1:0] unblock_window;
      logic [1:0] guard_stretch;
      logic [1:0] trip_stretch;
      logic [3:0] pretrip_delay;
   } cfg_t;

   // shipped settings: all timers disabled, guard before trip on
   localparam logic [31:0] CFG_RESET = 32'h0000_0800;

   typedef struct packed {
      logic guard;
      logic trip;
      logic low;
      logic noise;
   } rx_t;

   typedef struct packed {
      logic trip;
      logic guard;
      logic checkback;
      logic low_level;
      logic armed;
      logic override;
      logic unblock;
   } chan_out_t;

   function automatic logic [10:0] stretch_ms(input logic [1:0] code);
      case (code)
         2'h1: stretch_ms = 11'h00a;
         2'h2: stretch_ms = 11'h032;
         2'h3: stretch_ms = 11'h064;
         default: stretch_ms = 11'h000;
      endcase
   endfunction

   function automatic logic [10:0] window_ms(input logic [1:0] code);
      case (code)
         2'h1: window_ms = 11'h096;
         2'h2: window_ms = 11'h12c;
         2'h3: window_ms = 11'h1f4;
         default: window_ms = 11'h000;
      endcase
   endfunction

   function automatic logic [10:0] low_delay_ms(input logic [2:0] code);
      case (code)
         3'h1: low_delay_ms = 11'h00a;
         3'h2: low_delay_ms = 11'h00f;
         3'h3: low_delay_ms = 11'h014;
         3'h4: low_delay_ms = 11'h028;
         default: low_delay_ms = 11'h000;
      endcase
   endfunction

   function automatic logic [10:0] sat_inc(input logic [10:0] v);
      sat_inc = (v == MS_MAX) ? v : v + 11'h001;
   endfunction

   // one millisecond timer step: counts ticks while run holds, restarts at zero otherwise
   function automatic logic [10:0] timer_next(input logic run, input logic tick, input logic [10:0] v);
      if (!run) begin
         timer_next = 11'h000;
      end else if (tick) begin
         timer_next = sat_inc(v);
      end else begin
         timer_next = v;
      end
   endfunction

endpackage

/* File: rtl/dircomp_trip_logic.sv */
// directional comparison receiver trip logic with ahb-lite configuration slave
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
module trip_channel
   import trip_logic_pkg::*;
(
   input wire logic hclk, // module clock
   input wire logic hresetn, // async reset, active low
   input wire logic tick, // 1 ms pulse
   input wire logic unblock_allowed, // channel may run unblock
   input trip_logic_pkg::rx_t rx, // synchronised receiver indications
   input trip_logic_pkg::cfg_t cfg, // switch settings
   output trip_logic_pkg::chan_out_t out_r // registered channel outputs
);
   logic [10:0] low_cnt_r;
   logic [10:0] guard_cnt_r;
   logic [10:0] trip_cnt_r;
   logic [10:0] noguard_cnt_r;
   logic [10:0] ub_cnt_r;
   logic [10:0] trip_hold_r;
   logic [10:0] guard_hold_r;
   logic armed_r;
   logic override_r;
   logic locked_r;
   logic low_ok;
   logic loss_dly;
   logic tag_expired;
   logic ub_enabled;
   logic ub_active;
   logic ub_expired;
   logic pre_ok;
   logic allow;
   logic logic_trip;
   logic own_guard;

   // counters saturate at the top of their range; every span must stay below it
   if (OVR_TRIP_MS >= MS_MAX) begin : g_bad_span
      $error("millisecond span beyond counter range");
   end

   // low level delay gates both unblock start and low level output
   assign low_ok = rx.low && (low_cnt_r >= low_delay_ms(cfg.low_delay));
   assign loss_dly = low_ok && !rx.guard;
   assign tag_expired = noguard_cnt_r >= TAG_MS;
   assign ub_enabled = unblock_allowed && (cfg.unblock_window != 2'h0);
   assign ub_active = ub_enabled && loss_dly && (ub_cnt_r < window_ms(cfg.unblock_window));
   assign ub_expired = ub_enabled && loss_dly && !ub_active;
   assign pre_ok = trip_cnt_r >= (PRETRIP_STEP_MS * {7'h00, cfg.pretrip_delay});
   // unused mode code keeps the secure behaviour of plain guard before trip
   // lockouts hold even with guard before trip off; only open breaker override passes them
   assign allow = override_r || (!locked_r && ((cfg.gbt_mode == GBT_OFF) || armed_r));
   assign logic_trip = (rx.trip && pre_ok && allow) ||
                       (ub_active && !(rx.noise && cfg.noise_blocks_unblock));
   assign own_guard = rx.guard && !logic_trip;

   // each of the five interval timers counts ticks while its condition holds and restarts at zero otherwise
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_cnt_r <= 11'h000;
      end else begin
         low_cnt_r <= timer_next(rx.low, tick, low_cnt_r);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         guard_cnt_r <= 11'h000;
      end else begin
         guard_cnt_r <= timer_next(rx.guard, tick, guard_cnt_r);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trip_cnt_r <= 11'h000;
      end else begin
         trip_cnt_r <= timer_next(rx.trip, tick, trip_cnt_r);
      end
   end

   // either tone counts as the channel being present
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         noguard_cnt_r <= 11'h000;
      end else begin
         noguard_cnt_r <= timer_next(!(rx.guard || rx.trip), tick, noguard_cnt_r);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ub_cnt_r <= 11'h000;
      end else begin
         ub_cnt_r <= timer_next(loss_dly, tick, ub_cnt_r);
      end
   end

   // armed only after a full guard interval; starts disarmed for security
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         armed_r <= 1'b0;
      end else if (loss_dly || tag_expired || ub_expired) begin
         armed_r <= 1'b0;
      end else if (guard_cnt_r >= GBT_MS) begin
         armed_r <= 1'b1;
      end
   end

   // trip after guard and unblock expiry lock out every mode except a set open breaker override until a full guard interval
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         locked_r <= 1'b0;
      end else if (tag_expired || ub_expired) begin
         locked_r <= 1'b1;
      end else if (guard_cnt_r >= GBT_MS) begin
         locked_r <= 1'b0;
      end
   end

   // open breaker override; set and clear need trip and guard, which never coexist long
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         override_r <= 1'b0;
      end else if (cfg.gbt_mode == GBT_OVERRIDE && trip_cnt_r > OVR_TRIP_MS) begin
         override_r <= 1'b1;
      end else if (guard_cnt_r >= OVR_RESTORE_MS) begin
         override_r <= 1'b0;
      end
   end

   // hold timers only stretch the outputs, they feed nothing back
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trip_hold_r <= 11'h000;
      end else if (logic_trip) begin
         trip_hold_r <= stretch_ms(cfg.trip_stretch);
      end else if (tick && trip_hold_r != 11'h000) begin
         trip_hold_r <= trip_hold_r - 11'h001;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         guard_hold_r <= 11'h000;
      end else if (own_guard) begin
         guard_hold_r <= stretch_ms(cfg.guard_stretch);
      end else if (tick && guard_hold_r != 11'h000) begin
         guard_hold_r <= guard_hold_r - 11'h001;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         out_r <= '0;
      end else begin
         out_r.trip <= logic_trip || (trip_hold_r != 11'h000);
         out_r.guard <= own_guard || (guard_hold_r != 11'h000);
         out_r.checkback <= logic_trip || (rx.trip && pre_ok);
         out_r.low_level <= low_ok;
         out_r.armed <= armed_r;
         out_r.override <= override_r;
         out_r.unblock <= ub_active;
      end
   end
endmodule // trip_channel

////////////////////////////////////////////////////////////////////////////////
module dircomp_trip_logic
   import trip_logic_pkg::*;
#(
   parameter int unsigned TICK_CYCLES_P = TICK_CYCLES, // clock cycles per millisecond
   parameter bit THREE_FREQ = 1'b0 // 1: separate transfer-trip channel
)(
   input wire logic hclk, // module and bus clock
   input wire logic hresetn, // async reset, active low
   input wire logic hsel, // ahb slave select
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size, word only
   input wire logic hready, // ahb bus ready
   input wire logic [31:0] hwdata, // ahb write data
   output logic hreadyout, // ahb slave ready
   output logic hresp, // ahb response, always okay
   output logic [31:0] hrdata, // ahb read data
   input wire logic rx_guard, // guard frequency received
   input wire logic rx_trip, // trip (unblock side in 3f) frequency received
   input wire logic rx_dtt_trip, // transfer-trip frequency received, 3f only
   input wire logic rx_low, // low receive level
   input wire logic rx_noise, // noise detected
   output logic trip_out, // unblock/permissive trip output
   output logic guard_out, // guard output of the unblock side
   output logic checkback_out, // checkback trip output
   output logic low_level_n, // low level output, active low
   output logic noise_out, // noise indication
   output logic relay_trip_pos, // relay line driven positive: transfer trip in 3f, unblock trip otherwise
   output logic relay_trip_neg, // relay line driven negative: unblock trip without transfer trip in 3f, held low otherwise
   output logic relay_guard // guard to the relay card
);
   logic [4:0] sync1_r;
   logic [4:0] sync2_r;
   logic [16:0] tick_cnt_r;
   logic tick_r;
   logic [31:0] cfg_ub_r;
   logic [31:0] cfg_dtt_r;
   logic wr_pend_r;
   logic [7:0] wr_addr_r;
   rx_t rx_ub;
   rx_t rx_dtt;
   chan_out_t ub_out;
   chan_out_t dtt_out;
   logic addr_phase;
   logic [31:0] rd_word;

   if (TICK_CYCLES_P < 2 || TICK_CYCLES_P > 17'h1ffff) begin : g_bad_tick
      $error("tick cycles out of range");
   end

   ////////////////////////////////////////////////////////////////////////////
   // two flops per receiver input; only the second stage feeds logic
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1_r <= 5'h00;
         sync2_r <= 5'h00;
      end else begin
         sync1_r <= {rx_dtt_trip, rx_noise, rx_low, rx_trip, rx_guard};
         sync2_r <= sync1_r;
      end
   end

   assign rx_ub = '{guard: sync2_r[0], trip: sync2_r[1], low: sync2_r[2], noise: sync2_r[3]};
   assign rx_dtt = '{guard: sync2_r[0], trip: sync2_r[4], low: sync2_r[2], noise: sync2_r[3]};

   // common millisecond tick
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tick_cnt_r <= 17'h00000;
         tick_r <= 1'b0;
      end else if (tick_cnt_r == 17'(TICK_CYCLES_P - 1)) begin
         tick_cnt_r <= 17'h00000;
         tick_r <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 17'h00001;
         tick_r <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // ahb-lite slave, zero wait states; write lands in the data phase
   assign addr_phase = hsel && htrans[1] && hready;

   always_comb begin
      case (haddr[7:0])
         CFG_UB_OFS: rd_word = cfg_ub_r;
         CFG_DTT_OFS: rd_word = cfg_dtt_r;
         STATUS_OFS: rd_word = {11'h000, sync2_r, dtt_out, ub_out, 2'h0};
         default: rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         wr_addr_r <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         wr_pend_r <= addr_phase && hwrite;
         wr_addr_r <= haddr[7:0];
         if (addr_phase && !hwrite) begin
            hrdata <= rd_word;
         end
      end
   end

   // bits 31:16 hold no switches; they read back zero whatever is written
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cfg_ub_r <= CFG_RESET;
         cfg_dtt_r <= CFG_RESET;
      end else if (wr_pend_r) begin
         if (wr_addr_r == CFG_UB_OFS) begin
            cfg_ub_r <= {16'h0000, hwdata[15:0]};
         end
         if (wr_addr_r == CFG_DTT_OFS) begin
            cfg_dtt_r <= {16'h0000, hwdata[15:0]};
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // the unblock side is the only one that runs the loss of channel window
   trip_channel u_ub (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(tick_r),
      .unblock_allowed(1'b1),
      .rx(rx_ub),
      .cfg(cfg_t'(cfg_ub_r)),
      .out_r(ub_out)
   );

   // transfer-trip channel only runs in the three-frequency build
   trip_channel u_dtt (
      .hclk(hclk),
      .hresetn(hresetn),
      .tick(tick_r),
      .unblock_allowed(1'b0),
      .rx(THREE_FREQ ? rx_dtt : rx_t'(4'h0)),
      .cfg(cfg_t'(cfg_dtt_r)),
      .out_r(dtt_out)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trip_out <= 1'b0;
         guard_out <= 1'b0;
         checkback_out <= 1'b0;
         low_level_n <= 1'b1;
         noise_out <= 1'b0;
         relay_trip_pos <= 1'b0;
         relay_trip_neg <= 1'b0;
         relay_guard <= 1'b0;
      end else begin
         trip_out <= ub_out.trip;
         guard_out <= ub_out.guard;
         checkback_out <= ub_out.checkback || (THREE_FREQ && dtt_out.checkback);
         low_level_n <= !ub_out.low_level;
         noise_out <= sync2_r[3];
         if (THREE_FREQ) begin
            relay_trip_pos <= dtt_out.trip;
            relay_trip_neg <= ub_out.trip && !dtt_out.trip;
            relay_guard <= dtt_out.guard;
         end else begin
            relay_trip_pos <= ub_out.trip;
            relay_trip_neg <= 1'b0;
            relay_guard <= ub_out.guard;
         end
      end
   end
endmodule // dircomp_trip_logic

/* File: dv/trip_checker_asserts.sv */
// checker: bus and channel timing properties of the carrier trip logic
`timescale 1ns/100ps
module trip_checker #(
   parameter int unsigned TICK_CYCLES_P = 10,
   parameter bit THREE_FREQ = 1'b0
)(
   input wire logic hclk, // clock
   input wire logic hresetn, // reset, active low
   input wire logic hsel, // select
   input wire logic [1:0] htrans, // transfer type
   input wire logic hwrite, // write
   input wire logic hready, // bus ready
   input wire logic hreadyout, // slave ready
   input wire logic hresp, // response
   input wire logic [31:0] hrdata, // read data
   input wire logic rx_guard, // guard in
   input wire logic rx_low, // low level in
   input wire logic rx_noise, // noise in
   input wire logic trip_out, // trip
   input wire logic checkback_out, // checkback
   input wire logic low_level_n, // low level out
   input wire logic noise_out, // noise out
   input wire logic relay_trip_pos, // relay positive
   input wire logic relay_trip_neg // relay negative
);
   int guard_run_r;
   logic armed_seen_r;
   logic cfg_touched_r;
   logic [3:0] low_age_r;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // the guard bound is one tick short: the design's tick phase is free running
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         guard_run_r <= 0;
         armed_seen_r <= 1'b0;
         cfg_touched_r <= 1'b0;
         low_age_r <= 4'hf;
      end else begin
         guard_run_r <= rx_guard ? guard_run_r + 1 : 0;
         if (guard_run_r >= 119 * TICK_CYCLES_P) armed_seen_r <= 1'b1;
         if (hsel && htrans[1] && hwrite) cfg_touched_r <= 1'b1;
         low_age_r <= rx_low ? 4'h0 : ((low_age_r == 4'hf) ? low_age_r : low_age_r + 4'h1);
      end
   end
   AST_RESP_OKAY: assert property (hresp == 1'b0) else $error("hresp not okay");
   AST_READY_HIGH: assert property (hreadyout) else $error("hreadyout low");
   AST_RDATA_HOLD: assert property (!(hsel && htrans[1] && hready && !hwrite) |=> $stable(hrdata))
      else $error("hrdata moved without read");
   AST_CHECKBACK_TRIP: assert property ($rose(trip_out) |-> ##[0:1] checkback_out)
      else $error("trip without checkback");
   AST_GUARD_FIRST: assert property (!cfg_touched_r && $rose(trip_out) |-> armed_seen_r)
      else $error("trip before guard span");
   AST_NOISE_FOLLOW: assert property ($rose(rx_noise) |-> ##[2:5] noise_out)
      else $error("noise not passed on");
   AST_LOW_CAUSE: assert property ($fell(low_level_n) |-> low_age_r < 4'h8)
      else $error("low level out without low in");
   AST_NEG_IDLE: assert property (!THREE_FREQ |-> !relay_trip_neg)
      else $error("negative relay drive in two tone mode");
   AST_POS_TRIP: assert property (!THREE_FREQ && $rose(trip_out) |-> ##[0:1] relay_trip_pos)
      else $error("relay line not driven on trip");
   cover property ($rose(trip_out));
   cover property ($fell(low_level_n));
   cover property ($rose(noise_out));
endmodule // trip_checker

bind dircomp_trip_logic trip_checker #(.TICK_CYCLES_P(TICK_CYCLES_P), .THREE_FREQ(THREE_FREQ)) chk_i (
   .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hresp, .hrdata, .rx_guard, .rx_low,
   .rx_noise, .trip_out, .checkback_out, .low_level_n, .noise_out, .relay_trip_pos, .relay_trip_neg);

/* File: dv/rx_source.sv */
// receiver front end model: turns a line state code into detector levels
`timescale 1ns/100ps
module rx_source (
   input wire logic hclk, // clock
   input wire logic hresetn, // reset, active low
   input wire logic [2:0] cmd, // 0 guard 1 trip 2 loss 3 low+guard 4 loss+noise
   output logic guard, // guard tone
   output logic trip, // trip tone
   output logic low, // low level
   output logic noise, // noise
   output logic xfer // third tone, never sent
);
   // a dead line shows as low level, as a real receiver would report it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {guard, trip, low, noise, xfer} <= 5'h04;
      end else begin
         guard <= (cmd == 3'h0) || (cmd == 3'h3);
         trip <= (cmd == 3'h1);
         low <= (cmd >= 3'h2);
         noise <= (cmd == 3'h4);
         xfer <= 1'b0;
      end
   end
endmodule // rx_source

/* File: dv/tb.sv */
// testbench: scenario tasks for the carrier trip logic
`timescale 1ns/100ps
module tb;
   import trip_logic_pkg::*;
   localparam int TK = 10;
   localparam logic [2:0] G = 3'h0, T = 3'h1, L = 3'h2, LG = 3'h3, LN = 3'h4;
   logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0] htrans;
   logic [2:0] hsize, cmd;
   logic g, t, x, l, n, trip_out, guard_out, checkback_out, low_level_n, noise_out, rp, rn, rg;
   int error_cnt, compares;
   int sm[4] = '{0, 10, 50, 100};
   int wn[4] = '{0, 150, 300, 500};
   int ld[5] = '{0, 10, 15, 20, 40};
   assign hready = hreadyout;
   dircomp_trip_logic #(.TICK_CYCLES_P(TK)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hready, .hwdata, .hreadyout, .hresp, .hrdata, .rx_guard(g), .rx_trip(t), .rx_dtt_trip(x), .rx_low(l),
      .rx_noise(n), .trip_out, .guard_out, .checkback_out, .low_level_n, .noise_out, .relay_trip_pos(rp),
      .relay_trip_neg(rn), .relay_guard(rg));
   rx_source src (.hclk, .hresetn, .cmd, .guard(g), .trip(t), .low(l), .noise(n), .xfer(x));
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] dat);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= dat;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic cfg(input logic [31:0] v);
      ahb(1'b1, 32'(CFG_UB_OFS), v);
   endtask
   task automatic rx(input logic [2:0] c, input int ms);
      cmd <= c;
      repeat (ms * TK) @(posedge hclk);
   endtask
   task automatic sc_from_reset;
      rx(T, 20);
      chk("trip", 32'(trip_out), 0);
      chk("checkback", 32'(checkback_out), 1);
      rx(G, 100);
      rx(T, 5);
      chk("trip", 32'(trip_out), 0);
      rx(G, 130);
      rx(T, 5);
      chk("trip", 32'(trip_out), 1);
      chk("checkback", 32'(checkback_out), 1);
   endtask
   task automatic sc_modes;
      cfg(32'h0);
      rx(G, 130);
      rx(L, 130);
      rx(T, 5);
      chk("trip", 32'(trip_out), 0);
      for (int c = 0; c < 4; c++) begin
         cfg(32'(c) << 11);
         rx(G, 130);
         rx(L, 20);
         rx(T, 5);
         chk("trip", 32'(trip_out), 32'(c == 0));
      end
      cfg(32'h805);
      rx(G, 130);
      rx(T, 8);
      chk("trip", 32'(trip_out), 0);
      rx(T, 4);
      chk("trip", 32'(trip_out), 1);
   endtask
   task automatic sc_stretch;
      for (int c = 1; c < 4; c++) begin
         cfg(32'h800 | (32'(c) << 4) | (32'(c) << 6));
         rx(G, 130);
         rx(T, 20);
         rx(G, 5);
         chk("trip", 32'(trip_out), 1);
         chk("relay pos", 32'(rp), 1);
         chk("relay neg", 32'(rn), 0);
         chk("checkback", 32'(checkback_out), 0);
         rx(G, sm[c]);
         chk("trip", 32'(trip_out), 0);
         rx(L, 5);
         chk("guard", 32'(guard_out), 1);
         chk("relay guard", 32'(rg), 1);
         rx(L, sm[c]);
         chk("guard", 32'(guard_out), 0);
      end
   endtask
   task automatic sc_unblock;
      for (int c = 1; c < 4; c++) begin
         cfg(32'h800 | (32'(c) << 8));
         rx(G, 130);
         rx(LG, 20);
         chk("trip", 32'(trip_out), 0);
         rx(L, 3);
         chk("trip", 32'(trip_out), 1);
         rx(L, wn[c] - 6);
         chk("trip", 32'(trip_out), 1);
         rx(L, 6);
         chk("trip", 32'(trip_out), 0);
         rx(T, 5);
         chk("trip", 32'(trip_out), 0);
      end
      for (int c = 1; c < 5; c++) begin
         cfg(32'h900 | (32'(c) << 13));
         rx(G, 130);
         rx(L, ld[c] - 3);
         chk("low", 32'(low_level_n), 1);
         chk("trip", 32'(trip_out), 0);
         rx(L, 6);
         chk("low", 32'(low_level_n), 0);
         chk("trip", 32'(trip_out), 1);
      end
      for (int k = 0; k < 2; k++) begin
         cfg(32'h900 | (32'(k) << 10));
         rx(G, 130);
         rx(LN, 10);
         chk("trip", 32'(trip_out), 32'(k == 0));
         chk("noise", 32'(noise_out), 1);
      end
   endtask
   task automatic sc_override;
      cfg(32'h1000);
      rx(G, 130);
      rx(T, 1100);
      ahb(1'b0, 32'(STATUS_OFS), 32'h0);
      chk("override", 32'(rd[3]), 1);
      rx(L, 20);
      rx(T, 5);
      chk("trip", 32'(trip_out), 1);
      rx(G, 150);
      ahb(1'b0, 32'(STATUS_OFS), 32'h0);
      chk("override", 32'(rd[3]), 1);
      rx(G, 60);
      ahb(1'b0, 32'(STATUS_OFS), 32'h0);
      chk("override", 32'(rd[3]), 0);
   endtask
   task automatic sc_regs;
      ahb(1'b0, 32'(CFG_DTT_OFS), 32'h0);
      chk("cfg reset", rd, 32'(CFG_RESET));
      ahb(1'b1, 32'(CFG_DTT_OFS), 32'hffff_ffff);
      ahb(1'b0, 32'(CFG_DTT_OFS), 32'h0);
      chk("cfg rw", rd, 32'h0000_ffff);
      ahb(1'b1, 32'h0000_0010, 32'hffff_ffff);
      ahb(1'b0, 32'h0000_0010, 32'h0);
      chk("unmapped", rd, 32'h0);
      ahb(1'b1, 32'(STATUS_OFS), 32'hffff_ffff);
      ahb(1'b0, 32'(STATUS_OFS), 32'h0);
      chk("status low bits", rd & 32'h3, 32'h0);
      ahb(1'b1, 32'(CFG_DTT_OFS), 32'(CFG_RESET));
   endtask
   task automatic test_done;
      $display("comparisons %0d errors %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // bound well above the roughly 60000 cycles the scenarios need
   initial begin
      repeat (90000) @(posedge hclk);
      error_cnt++;
      test_done();
   end
   initial begin
      hresetn = 1'b0;
      {hsel, hwrite, htrans, haddr, hwdata} = '0;
      hsize = 3'h2;
      cmd = L;
      error_cnt = 0;
      compares = 0;
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      sc_from_reset();
      sc_modes();
      sc_stretch();
      sc_unblock();
      sc_override();
      sc_regs();
      test_done();
   end
endmodule // tb
